// ---- include/short_fault_pkg.sv ----
// Purpose: constants for the output short fault manager
// Assumes: comparator results arrive as synchronous levels on clk_i (125 MHz)
// Notes: retry interval count is a parameter of the top module
package short_fault_pkg;
	// retry interval, printed figure kept as a plain default
	localparam int unsigned RETRY_TIME_US = 1000;
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned RETRY_CYCLES = RETRY_TIME_US * CLK_MHZ;
	localparam int unsigned CNT_W = 32;
	typedef enum logic [3:0] {
		ST_RUN = 4'b0001,
		ST_HOLD = 4'b0010,
		ST_THERMAL = 4'b0100,
		ST_RELEASE = 4'b1000
	} lc_state_e;
endpackage : short_fault_pkg

// ---- src/retry_timer.sv ----
// Purpose: retry interval timer
// Assumes: start is a one-cycle pulse
// Notes: done pulses once when the count completes
`timescale 1ns/1ps
`default_nettype none
module retry_timer #(
	parameter int unsigned TERMINAL = 16
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic start_i,
	output logic busy_o,
	output logic done_o
);
	import short_fault_pkg::*;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic busy;
	logic next_busy;
	logic done;
	logic next_done;
	always_comb begin
		next_count = count;
		next_busy = busy;
		next_done = 1'b0;
		if (start_i) begin
			next_count = '0;
			next_busy = 1'b1;
		end else if (busy) begin
			if (count == CNT_W'(TERMINAL - 1)) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end else begin
				next_count = count + 1'b1;
			end
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			count <= next_count;
			busy <= next_busy;
			done <= next_done;
		end
	end
	assign busy_o = busy;
	assign done_o = done;
endmodule : retry_timer
`default_nettype wire

// ---- src/output_short_fault_manager.sv ----
// Purpose: fault sequencer for the LED driver output stage
// Assumes: all comparator inputs synchronous to clk_i
// Notes: fault report is open drain, enable high pulls the line low
`timescale 1ns/1ps
`default_nettype none
module output_short_fault_manager #(
	parameter int unsigned RETRY_CYCLES_P = short_fault_pkg::RETRY_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic output_undervoltage_detect_i,
	input wire logic overcurrent_detect_i,
	input wire logic common_mode_high_i,
	input wire logic soft_start_enabled_i,
	input wire logic soft_start_reset_i,
	input wire logic dim_active_i,
	input wire logic switch_request_i,
	input wire logic over_temp_i,
	input wire logic temp_recovered_i,
	input wire logic fault_report_n_i,
	output logic fault_report_n_o,
	output logic fault_report_n_oe_o,
	output logic switch_enable_o,
	output logic dim_gate_drive_o,
	output logic soft_start_restart_o,
	output logic standby_o
);
	import short_fault_pkg::*;

	// ********************
	// fault qualification
	// ********************
	logic uv_fault;
	logic oc_fault;
	logic oc_report_only;
	logic oc_protect;
	assign uv_fault = output_undervoltage_detect_i && soft_start_enabled_i && dim_active_i;
	assign oc_fault = overcurrent_detect_i;
	assign oc_report_only = oc_fault && common_mode_high_i;
	assign oc_protect = oc_fault && !common_mode_high_i;

	// ********************
	// report-only latch with release delay
	// ********************
	logic report_fault;
	logic report_prev;
	logic next_report_prev;
	logic report_hold;
	logic next_report_hold;
	assign report_fault = uv_fault || oc_report_only;

	// ********************
	// sequencer
	// ********************
	lc_state_e state;
	lc_state_e next_state;
	logic start_timer;
	logic timer_busy;
	logic timer_done;
	logic restart_pulse;
	logic next_restart_pulse;

	always_comb begin
		next_state = state;
		next_report_prev = report_fault;
		next_report_hold = report_hold;
		next_restart_pulse = 1'b0;
		start_timer = 1'b0;
		unique case (state)
			ST_RUN: begin
				if (over_temp_i) begin
					next_state = ST_THERMAL;
				end else if (oc_protect) begin
					next_state = ST_HOLD;
					start_timer = 1'b1;
				end else if (report_prev && !report_fault && report_hold) begin
					start_timer = 1'b1;
				end
				if (report_fault) begin
					next_report_hold = 1'b1;
				end else if (timer_done && report_hold) begin
					next_report_hold = 1'b0;
					next_restart_pulse = 1'b1;
				end
			end
			ST_HOLD: begin
				if (over_temp_i) begin
					next_state = ST_THERMAL;
				end else if (timer_done) begin
					next_state = ST_RELEASE;
					next_restart_pulse = 1'b1;
				end
			end
			ST_RELEASE: begin
				if (over_temp_i) begin
					next_state = ST_THERMAL;
				end else if (oc_protect) begin
					next_state = ST_HOLD;
					start_timer = 1'b1;
				end else begin
					next_state = ST_RUN;
				end
			end
			ST_THERMAL: begin
				if (temp_recovered_i && !over_temp_i) begin
					next_state = ST_RUN;
					next_restart_pulse = 1'b1;
				end
			end
			default: begin
				next_state = ST_THERMAL;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= ST_RUN;
			report_prev <= 1'b0;
			report_hold <= 1'b0;
			restart_pulse <= 1'b0;
		end else begin
			state <= next_state;
			report_prev <= next_report_prev;
			report_hold <= next_report_hold;
			restart_pulse <= next_restart_pulse;
		end
	end

	retry_timer #(
		.TERMINAL(RETRY_CYCLES_P)
	) u_retry_timer (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.start_i(start_timer),
		.busy_o(timer_busy),
		.done_o(timer_done)
	);

	// ********************
	// outputs
	// ********************
	logic pull_low;
	logic next_pull_low;
	logic switch_en;
	logic next_switch_en;
	logic dim_gate;
	logic next_dim_gate;
	always_comb begin
		next_pull_low = report_hold || report_fault || state == ST_HOLD || state == ST_THERMAL;
		next_switch_en = state != ST_HOLD && state != ST_THERMAL && !soft_start_reset_i;
		next_dim_gate = next_switch_en && switch_request_i;
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pull_low <= 1'b0;
			switch_en <= 1'b0;
			dim_gate <= 1'b0;
		end else begin
			pull_low <= next_pull_low;
			switch_en <= next_switch_en;
			dim_gate <= next_dim_gate;
		end
	end
	assign fault_report_n_o = 1'b0;
	assign fault_report_n_oe_o = pull_low;
	assign switch_enable_o = switch_en;
	assign dim_gate_drive_o = dim_gate;
	assign soft_start_restart_o = restart_pulse;
	assign standby_o = state == ST_THERMAL;

	// ********************
	// assertions
	// ********************
	int unsigned gap;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			gap <= 0;
		end else if (start_timer) begin
			gap <= 0;
		end else if (gap < RETRY_CYCLES_P + 4) begin
			gap <= gap + 1;
		end
	end

	uv_reports_low_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		uv_fault |=> fault_report_n_oe_o) else $error("undervoltage not reported");
	uv_blanked_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(!soft_start_enabled_i || !dim_active_i) |-> !uv_fault) else $error("undervoltage not blanked");
	uv_keeps_switching_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state == ST_RUN && !over_temp_i && !oc_protect && !soft_start_reset_i) |=> switch_enable_o)
		else $error("report-only fault stopped switching");
	oc_stops_switch_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state == ST_RUN && oc_protect && !over_temp_i) |=> ##1 (!switch_enable_o && !dim_gate_drive_o
		&& fault_report_n_oe_o)) else $error("low common-mode overcurrent not handled");
	ss_reset_stops_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		soft_start_reset_i |=> (!switch_enable_o && !dim_gate_drive_o)) else $error("soft-start reset ignored");
	hold_length_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		($rose(state == ST_RELEASE)) |-> gap == RETRY_CYCLES_P + 1) else $error("hold length wrong");
	release_restart_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state == ST_HOLD && timer_done && !over_temp_i) |=> soft_start_restart_o) else $error("no restart");
	thermal_stays_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state == ST_THERMAL && !temp_recovered_i) |=> (standby_o && fault_report_n_oe_o))
		else $error("left thermal standby early");
	report_release_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state == ST_RUN && $fell(report_fault) && report_hold && !oc_protect && !over_temp_i)
		|=> ##1 fault_report_n_oe_o) else $error("report released too early");
	resume_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state == ST_RELEASE) |=> (oc_protect ? 1'b1 : state == ST_RUN)) else $error("bad restart decision");

	hiccup_c: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		state == ST_HOLD ##1 state == ST_RELEASE ##1 state == ST_HOLD);
	thermal_c: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		state == ST_THERMAL ##1 state == ST_RUN);
	uv_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) $fell(report_hold));

	// ********************
	// report path and standby checks
	// ********************
	pin_data_low_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		1'b1
		|-> fault_report_n_o == 1'b0)
		else $error("open-drain data not low");

	report_restart_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state == ST_RUN && timer_done && report_hold && !report_fault && !over_temp_i && !oc_protect)
		|=> soft_start_restart_o)
		else $error("report release gave no restart");

	restart_single_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		soft_start_restart_o
		|=> !soft_start_restart_o)
		else $error("restart pulse longer than one cycle");

	oc_hi_no_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state == ST_RUN && oc_report_only && !over_temp_i)
		|=> state == ST_RUN)
		else $error("high common-mode overcurrent left run");

	standby_entry_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		over_temp_i
		|=> standby_o)
		else $error("over-temperature did not enter standby");

	standby_report_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		standby_o
		|=> fault_report_n_oe_o)
		else $error("standby not reported");

	idle_released_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state == ST_RUN && !report_hold && !report_fault)
		|=> !fault_report_n_oe_o)
		else $error("report held without cause");

	dim_needs_switch_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		dim_gate_drive_o
		|-> switch_enable_o)
		else $error("dimming gate on while switching stopped");

	report_hiccup_c: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		soft_start_restart_o && state == ST_RUN);
	oc_hi_c: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		oc_report_only ##1 fault_report_n_oe_o);
endmodule : output_short_fault_manager
`default_nettype wire

// ---- bench/fault_host_model.sv ----
// Purpose: host side of the open-drain fault report line
// Assumes: pull-up on the line, optional strap to the soft-start node
// Notes: behavioural, no clock
`timescale 1ns/1ps
`default_nettype none
module fault_host_model (
	input wire logic fault_report_n_o,
	input wire logic fault_report_n_oe_o,
	input wire logic tie_ss_i,
	output logic pin_level_o,
	output logic ss_reset_o
);
	// pull-up wins whenever the device lets go
	assign pin_level_o = fault_report_n_oe_o ? fault_report_n_o : 1'b1;
	// strap pulls soft-start below reset level
	assign ss_reset_o = tie_ss_i & ~pin_level_o;
endmodule : fault_host_model
`default_nettype wire

// ---- bench/output_short_fault_manager_tb.sv ----
// Purpose: self-checking bench for the fault sequencer
// Assumes: short retry count of 16 cycles
// Notes: one task per scenario
`timescale 1ns/1ps
`default_nettype none
module output_short_fault_manager_tb;
	import short_fault_pkg::*;
	localparam int RP = 16;
	logic clk_i = 0, reset_n_i = 0, uv = 0, oc = 0, cmh = 0, ssen = 1, dima = 1, ot = 0, trec = 1, tie = 0;
	logic pin, ssrst, ss_en_w, fr_o, oe, sw, dim, rst_p, stby;
	int fail_count = 0, n_checks = 0, cyc = 0, c, k;
	always #4 clk_i = ~clk_i;
	// soft-start falls out of enable while held in reset
	assign ss_en_w = ssen & ~ssrst;
	output_short_fault_manager #(.RETRY_CYCLES_P(RP)) u_output_short_fault_manager (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .output_undervoltage_detect_i(uv), .overcurrent_detect_i(oc),
		.common_mode_high_i(cmh), .soft_start_enabled_i(ss_en_w), .soft_start_reset_i(ssrst),
		.dim_active_i(dima), .switch_request_i(1'b1), .over_temp_i(ot), .temp_recovered_i(trec),
		.fault_report_n_i(pin), .fault_report_n_o(fr_o), .fault_report_n_oe_o(oe), .switch_enable_o(sw),
		.dim_gate_drive_o(dim), .soft_start_restart_o(rst_p), .standby_o(stby));
	fault_host_model u_fault_host_model (.fault_report_n_o(fr_o), .fault_report_n_oe_o(oe), .tie_ss_i(tie),
		.pin_level_o(pin), .ss_reset_o(ssrst));
	task wrap_up;
		if (fail_count == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : wrap_up
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			wrap_up();
		end
	end
	task chk(input logic ok);
		n_checks++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("[ERR] %0t check failed", $time);
		end
	endtask : chk
	task step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : step
	task wait_oe(input logic v, output int n);
		n = 0;
		while (oe !== v && n < 60) begin
			step(1);
			n++;
		end
	endtask : wait_oe
	task count_rst(input int n, output int p);
		p = 0;
		repeat (n) begin
			step(1);
			if (rst_p === 1'b1) p++;
		end
	endtask : count_rst
	task t_uv;
		@(posedge clk_i) uv <= 1'b1;
		step(2);
		chk(oe === 1'b1 && pin === 1'b0);
		chk(sw === 1'b1 && dim === 1'b1);
		@(posedge clk_i) uv <= 1'b0;
		wait_oe(1'b0, c);
		chk(c >= RP && c <= RP + 4);
	endtask : t_uv
	task t_blank;
		@(posedge clk_i) begin
			dima <= 1'b0;
			uv <= 1'b1;
		end
		step(4);
		chk(oe === 1'b0);
		@(posedge clk_i) begin
			dima <= 1'b1;
			ssen <= 1'b0;
		end
		step(4);
		chk(oe === 1'b0);
		@(posedge clk_i) begin
			uv <= 1'b0;
			ssen <= 1'b1;
		end
	endtask : t_blank
	task t_oc_hi;
		@(posedge clk_i) begin
			cmh <= 1'b1;
			oc <= 1'b1;
		end
		step(2);
		chk(oe === 1'b1);
		chk(sw === 1'b1 && dim === 1'b1);
		@(posedge clk_i) oc <= 1'b0;
		wait_oe(1'b0, c);
		chk(c >= RP && c <= RP + 4);
		@(posedge clk_i) cmh <= 1'b0;
	endtask : t_oc_hi
	task t_oc_lo;
		@(posedge clk_i) oc <= 1'b1;
		step(3);
		chk(oe === 1'b1 && sw === 1'b0 && dim === 1'b0);
		count_rst(3 * RP + 10, k);
		chk(k >= 2);
		@(posedge clk_i) oc <= 1'b0;
		step(2 * RP + 8);
		chk(oe === 1'b0 && sw === 1'b1 && dim === 1'b1);
	endtask : t_oc_lo
	task t_thermal;
		@(posedge clk_i) begin
			ot <= 1'b1;
			trec <= 1'b0;
		end
		step(3);
		chk(stby === 1'b1 && oe === 1'b1 && sw === 1'b0);
		@(posedge clk_i) ot <= 1'b0;
		step(RP + 8);
		chk(stby === 1'b1 && sw === 1'b0);
		@(posedge clk_i) trec <= 1'b1;
		step(RP + 8);
		chk(stby === 1'b0);
	endtask : t_thermal
	task t_hiccup;
		@(posedge clk_i) begin
			tie <= 1'b1;
			uv <= 1'b1;
		end
		step(3);
		chk(ssrst === 1'b1 && sw === 1'b0 && dim === 1'b0);
		count_rst(2 * RP + 12, k);
		chk(k >= 1);
		@(posedge clk_i) begin
			uv <= 1'b0;
			tie <= 1'b0;
		end
		step(2 * RP + 8);
		chk(oe === 1'b0 && pin === 1'b1);
	endtask : t_hiccup
	initial begin
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1'b1;
		step(2);
		t_uv();
		t_blank();
		t_oc_hi();
		t_oc_lo();
		t_thermal();
		t_hiccup();
		wrap_up();
	end
endmodule : output_short_fault_manager_tb
`default_nettype wire
